// ===== src/two_wire_pkg.sv
// Functional notes
// - Bus uses exactly two lines, a clock line and a data line.
// - Lines are only pulled low or released, never driven high.
// - A line reads low if any party pulls it low.
// - A line is high only when all release; sample the real level.
// - Generated bus clock never exceeds 400 kbit/s.
// - Controller works as master or as slave.
// - In either role it can transmit or receive bytes.
// - Slaves are selected by a 7-bit address, 128 values.
// - Own address is programmable; general call recognition can be enabled.
// - Contention between masters resolves so only one completes.
// - Data changes while clock low; start and stop while clock high.
// - Address packet: 7 address bits, read/write, acknowledge in ninth clock.
// - Bytes go most significant bit first; all-zero address is general call.
// - Master reading low after sending high loses and becomes slave.
`default_nettype none
package two_wire_pkg;
  localparam int          CLK_PERIOD_NS = 8;
  // Half bit time at 400 kbit/s; least time, so round up
  localparam int          SCL_HALF_NS   = 1250;
  localparam int          HALF_CYC_I    =
    (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  HALF_CYC      = 8'(HALF_CYC_I);
  localparam logic [7:0]  MID_CYC       = 8'(HALF_CYC_I / 2);
  localparam logic [6:0]  GC_ADDR       = 7'h00;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam logic [3:0]  BIT_PRE       = 4'hf;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_TX, PH_RX, PH_SKIP
  } phase_t;

  typedef enum logic [2:0] {
    G_IDLE, G_START, G_LOW, G_HIGH, G_STOPH, G_FREE
  } gen_t;
endpackage : two_wire_pkg
`default_nettype wire

// ===== src/bus_line_if.sv
`default_nettype none
// Synchronised line levels and the events found on them
interface bus_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport sync_mp (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport core_mp (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : bus_line_if
`default_nettype wire

// ===== src/line_sync.sv
`default_nettype none
module line_sync (
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  bus_line_if.sync_mp lb
);
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;

  // two-stage synchroniser
  // Stage one feeds stage two only; stage three holds the prior level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      s3_r <= 2'h3;
    end else begin
      s1_r <= {scl_i, sda_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign lb.scl      = s2_r[1];
  assign lb.sda      = s2_r[0];
  assign lb.scl_rise = s2_r[1] & ~s3_r[1];
  assign lb.scl_fall = ~s2_r[1] & s3_r[1];
  assign lb.start_det = s2_r[1] & s3_r[1] & ~s2_r[0] & s3_r[0];
  assign lb.stop_det  = s2_r[1] & s3_r[1] & s2_r[0] & ~s3_r[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_START_SEEN: assert property (
    (s2_r[1] && s3_r[1] && $fell(s2_r[0])) |-> lb.start_det)
    else $error("start condition missed");
  AST_SYNC_LAG: assert property (
    ##3 (lb.scl == $past(scl_i, 2)))
    else $error("clock line sync lag wrong");
endmodule : line_sync
`default_nettype wire

// ===== src/two_wire_serial_bus.sv
`default_nettype none
module two_wire_serial_bus (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oe_n,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic       en,
  input  wire logic [6:0] own_addr,
  input  wire logic       gc_en,
  input  wire logic       m_go,
  input  wire logic [6:0] m_addr,
  input  wire logic       m_rw,
  input  wire logic       m_stop,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            tx_taken,
  output logic            slv_sel,
  output logic            busy,
  output logic            is_master,
  output logic            arb_lost,
  output logic            nack_seen
);
  bus_line_if lb ();

  two_wire_pkg::phase_t phase_r;
  two_wire_pkg::gen_t   gen_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_in_r;
  logic [7:0] sh_out_r;
  logic [7:0] go_r;
  logic [7:0] tmr_r;
  logic       eng_low_r;
  logic       ack_r;
  logic       sel_r;
  logic       gen_scl_low_r;
  logic       gen_sda_low_r;
  logic       stop_cond;

  line_sync u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .lb    (lb.sync_mp)
  );

  // seven-bit match, general call only with write
  function automatic logic addr_hit(input logic [7:0] b,
                                    input logic [6:0] own,
                                    input logic       gce);
    addr_hit = (b[7:1] == own) ||
               (gce && b[7:1] == two_wire_pkg::GC_ADDR && !b[0]);
  endfunction : addr_hit

  assign cnt_nxt = (cnt_r == two_wire_pkg::ACK_SLOT) ? 4'h0 : cnt_r + 4'h1;
  assign stop_cond = is_master && phase_r == two_wire_pkg::PH_SKIP &&
                     cnt_r == 4'h0;

  // Bit engine: samples on clock rise, changes data after clock fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r   <= two_wire_pkg::PH_IDLE;
      cnt_r     <= two_wire_pkg::BIT_PRE;
      sh_in_r   <= 8'h00;
      sh_out_r  <= 8'h00;
      eng_low_r <= 1'b0;
      ack_r     <= 1'b0;
      sel_r     <= 1'b0;
      is_master <= 1'b0;
      busy      <= 1'b0;
      rx_byte   <= 8'h00;
      rx_valid  <= 1'b0;
      tx_taken  <= 1'b0;
      slv_sel   <= 1'b0;
      arb_lost  <= 1'b0;
      nack_seen <= 1'b0;
    end else begin
      rx_valid  <= 1'b0;
      tx_taken  <= 1'b0;
      slv_sel   <= 1'b0;
      arb_lost  <= 1'b0;
      nack_seen <= 1'b0;
      if (!en) begin
        phase_r   <= two_wire_pkg::PH_IDLE;
        eng_low_r <= 1'b0;
        is_master <= 1'b0;
        busy      <= 1'b0;
      end else if (lb.start_det) begin
        // master when this end issued the start
        busy      <= 1'b1;
        phase_r   <= two_wire_pkg::PH_ADDR;
        cnt_r     <= two_wire_pkg::BIT_PRE;
        sh_out_r  <= go_r;
        sel_r     <= 1'b0;
        eng_low_r <= 1'b0;
        is_master <= (gen_r == two_wire_pkg::G_START);
      end else if (lb.stop_det) begin
        busy      <= 1'b0;
        phase_r   <= two_wire_pkg::PH_IDLE;
        eng_low_r <= 1'b0;
        is_master <= 1'b0;
      end else if (lb.scl_rise && phase_r != two_wire_pkg::PH_IDLE &&
                   cnt_r != two_wire_pkg::BIT_PRE) begin
        if (cnt_r < two_wire_pkg::ACK_SLOT) begin
          sh_in_r <= {sh_in_r[6:0], lb.sda};
        end else begin
          ack_r <= ~lb.sda;
        end
        if (is_master && cnt_r < two_wire_pkg::ACK_SLOT &&
            (phase_r == two_wire_pkg::PH_ADDR ||
             phase_r == two_wire_pkg::PH_TX) &&
            !eng_low_r && !lb.sda) begin
          is_master <= 1'b0;
          arb_lost  <= 1'b1;
          eng_low_r <= 1'b0;
          if (phase_r == two_wire_pkg::PH_TX) begin
            phase_r <= two_wire_pkg::PH_SKIP;
          end
        end
      end else if (lb.scl_fall && phase_r != two_wire_pkg::PH_IDLE) begin
        cnt_r <= cnt_nxt;
        if (cnt_nxt == two_wire_pkg::ACK_SLOT) begin
          unique case (phase_r)
            two_wire_pkg::PH_ADDR: begin
              sel_r     <= !is_master && addr_hit(sh_in_r, own_addr, gc_en);
              eng_low_r <= !is_master && addr_hit(sh_in_r, own_addr, gc_en);
              slv_sel   <= !is_master && addr_hit(sh_in_r, own_addr, gc_en);
            end
            two_wire_pkg::PH_RX: begin
              eng_low_r <= !(is_master && m_stop);
              rx_byte   <= sh_in_r;
              rx_valid  <= 1'b1;
            end
            default: eng_low_r <= 1'b0;
          endcase
        end else if (cnt_r == two_wire_pkg::ACK_SLOT) begin
          // direction after address, loser checks selection
          eng_low_r <= 1'b0;
          nack_seen <= !ack_r && phase_r != two_wire_pkg::PH_RX &&
                       phase_r != two_wire_pkg::PH_SKIP;
          if ((phase_r == two_wire_pkg::PH_ADDR &&
               ((is_master && ack_r && !sh_in_r[0] && !m_stop) ||
                (sel_r && sh_in_r[0]))) ||
              (phase_r == two_wire_pkg::PH_TX && ack_r &&
               !(is_master && m_stop))) begin
            phase_r   <= two_wire_pkg::PH_TX;
            sh_out_r  <= tx_byte;
            tx_taken  <= 1'b1;
            eng_low_r <= ~tx_byte[7];
          end else if ((phase_r == two_wire_pkg::PH_ADDR &&
                        ((is_master && ack_r && sh_in_r[0]) ||
                         (sel_r && !sh_in_r[0]))) ||
                       (phase_r == two_wire_pkg::PH_RX &&
                        !(is_master && m_stop))) begin
            phase_r <= two_wire_pkg::PH_RX;
          end else begin
            phase_r <= two_wire_pkg::PH_SKIP;
          end
        end else if ((phase_r == two_wire_pkg::PH_ADDR && is_master) ||
                     phase_r == two_wire_pkg::PH_TX) begin
          eng_low_r <= ~sh_out_r[3'(4'h7 - cnt_nxt)];
        end else begin
          eng_low_r <= 1'b0;
        end
      end
    end
  end

  // Clock generator; waits on the real line so slow slaves can stretch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gen_r         <= two_wire_pkg::G_IDLE;
      tmr_r         <= 8'h00;
      go_r          <= 8'h00;
      gen_scl_low_r <= 1'b0;
      gen_sda_low_r <= 1'b0;
    end else if (!en) begin
      gen_r         <= two_wire_pkg::G_IDLE;
      gen_scl_low_r <= 1'b0;
      gen_sda_low_r <= 1'b0;
    end else begin
      if (tmr_r != 8'h00) begin
        tmr_r <= tmr_r - 8'h01;
      end
      unique case (gen_r)
        two_wire_pkg::G_IDLE: begin
          gen_scl_low_r <= 1'b0;
          gen_sda_low_r <= 1'b0;
          // Only a free, quiet bus may be seized
          if (m_go && !busy && lb.scl && lb.sda) begin
            go_r          <= {m_addr, m_rw};
            gen_sda_low_r <= 1'b1;
            tmr_r         <= two_wire_pkg::HALF_CYC;
            gen_r         <= two_wire_pkg::G_START;
          end
        end
        two_wire_pkg::G_START: begin
          if (tmr_r == 8'h00) begin
            gen_scl_low_r <= 1'b1;
            tmr_r         <= two_wire_pkg::HALF_CYC;
            gen_r         <= two_wire_pkg::G_LOW;
          end
        end
        two_wire_pkg::G_LOW: begin
          if (tmr_r == two_wire_pkg::MID_CYC) begin
            gen_sda_low_r <= stop_cond;
          end
          if (tmr_r == 8'h00) begin
            gen_scl_low_r <= 1'b0;
            tmr_r         <= two_wire_pkg::HALF_CYC;
            if (!is_master) begin
              gen_r <= two_wire_pkg::G_IDLE;
            end else if (stop_cond) begin
              gen_r <= two_wire_pkg::G_STOPH;
            end else begin
              gen_r <= two_wire_pkg::G_HIGH;
            end
          end
        end
        two_wire_pkg::G_HIGH: begin
          if (!is_master) begin
            gen_r <= two_wire_pkg::G_IDLE;
          end else if (lb.scl_fall || (lb.scl && tmr_r == 8'h00)) begin
            gen_scl_low_r <= 1'b1;
            tmr_r         <= two_wire_pkg::HALF_CYC;
            gen_r         <= two_wire_pkg::G_LOW;
          end else if (!lb.scl) begin
            tmr_r <= two_wire_pkg::HALF_CYC;
          end
        end
        two_wire_pkg::G_STOPH: begin
          if (!lb.scl) begin
            tmr_r <= two_wire_pkg::HALF_CYC;
          end else if (tmr_r == 8'h00) begin
            gen_sda_low_r <= 1'b0;
            tmr_r         <= two_wire_pkg::HALF_CYC;
            gen_r         <= two_wire_pkg::G_FREE;
          end
        end
        two_wire_pkg::G_FREE: begin
          if (tmr_r == 8'h00) begin
            gen_r <= two_wire_pkg::G_IDLE;
          end
        end
        default: gen_r <= two_wire_pkg::G_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_n <= ~gen_scl_low_r;
      sda_oe_n <= ~(gen_sda_low_r | eng_low_r);
    end
  end

  // Helper: length of each generated low phase
  localparam int HALF_MIN = two_wire_pkg::HALF_CYC_I;
  logic [8:0] low_len_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_len_r <= 9'h000;
    end else if (!gen_scl_low_r) begin
      low_len_r <= 9'h000;
    end else if (low_len_r != 9'h1ff) begin
      low_len_r <= low_len_r + 9'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_NO_HIGH_DRIVE: assert property (
    scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
  AST_IDLE_RELEASE: assert property (
    (!en)[*3] |-> scl_oe_n && sda_oe_n && !busy)
    else $error("lines held while disabled");
  AST_LOW_LEN: assert property (
    ($fell(gen_scl_low_r) && $past(en)) |-> $past(low_len_r) >= HALF_MIN)
    else $error("clock low phase too short");
  AST_ARB_LOSS: assert property (
    (is_master && lb.scl_rise && !lb.start_det && !lb.stop_det && en &&
     phase_r == two_wire_pkg::PH_ADDR && cnt_r < 4'h8 && !eng_low_r &&
     !lb.sda) |=> !is_master && arb_lost)
    else $error("arbitration loss not taken");
  AST_SLAVE_ACK: assert property (
    (en && lb.scl_fall && !lb.start_det && !lb.stop_det && cnt_r == 4'h7 &&
     phase_r == two_wire_pkg::PH_ADDR && !is_master &&
     addr_hit(sh_in_r, own_addr, gc_en)) |=> eng_low_r ##2 !sda_oe_n)
    else $error("own address not acknowledged");
  AST_MSB_FIRST: assert property (
    (en && lb.scl_fall && !lb.start_det && !lb.stop_det &&
     phase_r == two_wire_pkg::PH_TX && cnt_r < 4'h7) |=>
    eng_low_r == !$past(sh_out_r[3'(4'h6 - cnt_r)]))
    else $error("transmit bit order wrong");
  AST_RX_BYTE: assert property (
    rx_valid |-> rx_byte == $past(sh_in_r))
    else $error("received byte mismatch");
  AST_GC_READ_IGNORED: assert property (
    (en && lb.scl_fall && cnt_r == 4'h7 && !lb.start_det && !lb.stop_det &&
     phase_r == two_wire_pkg::PH_ADDR && !is_master &&
     sh_in_r == 8'h01 && own_addr != 7'h00) |=> !eng_low_r)
    else $error("general call read acknowledged");

  COV_MASTER: cover property ($rose(is_master));
  COV_SLAVE:  cover property (slv_sel);
  COV_LOST:   cover property (arb_lost);
  COV_RX:     cover property (rx_valid && is_master);
endmodule : two_wire_serial_bus
`default_nettype wire

// ===== sim/bus_slave_model.sv
`default_nettype none
// Behavioural slave on the far side: only pulls the data line low or lets go
module bus_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  output logic            pull,
  output logic [7:0]      addr_byte,
  output logic [7:0]      data_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  int         bitn;
  int         nb;
  logic       sel;
  logic       rd;
  logic       act;

  // Idle: line released until a frame addresses us
  initial begin
    pull = 1'h0;
    act  = 1'h0;
    sel  = 1'h0;
    rd   = 1'h0;
  end

  always @(negedge sda) if (scl) begin
    act  = 1'h1;
    bitn = 0;
    nb   = 0;
    sel  = 1'h0;
  end

  always @(posedge sda) if (scl) act = 1'h0;

  // sample real level; a read ends on master refusal
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (sel && rd && nb > 1 && sda) act = 1'h0;
    bitn++;
  end

  // ack in ninth clock, data msb first
  // Changes land 24 ns after the fall so they never race the clock edge
  always @(negedge scl) if (act) begin
    if (bitn == 8) begin
      if (nb == 0) begin
        addr_byte = sh;
        sel       = (sh[7:1] == ADDR);
        rd        = sh[0];
      end else begin
        data_byte = sh;
      end
      pull <= #24 sel && (nb == 0 || !rd);
      nb++;
    end else begin
      if (bitn == 9) bitn = 0;
      pull <= #24 sel && rd && !rd_byte[7 - bitn];
    end
  end
endmodule : bus_slave_model
`default_nettype wire

// ===== sim/test_two_wire_serial_bus.sv
`default_nettype none
module test_two_wire_serial_bus;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'h0, nrst = 1'h0, en = 1'h0, gc_en = 1'h0;
  logic       m_go = 1'h0, m_rw = 1'h0, m_stop = 1'h0;
  logic       tscl = 1'h0, tsda = 1'h0, scl_q = 1'h1;
  logic [6:0] own_addr = 7'h2b, m_addr = 7'h00;
  logic [7:0] tx_byte = 8'h00, rd_byte = 8'h00;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, rx_valid, tx_taken;
  logic       slv_sel, busy, is_master, arb_lost, nack_seen, mpull;
  logic [7:0] rx_byte, addr_byte, data_byte;
  logic [8:0] r;
  wire logic  scl_w, sda_w;
  int         err_total = 0, total_checks = 0, k, per = 0, min_per;
  int         n_rxv, n_tx, n_sel, n_arb, n_nack, n_fall;

  // System clock, 8 ns
  always #4 clk = ~clk;

  assign scl_w = !((!scl_oe_n && !scl_o) || tscl);
  assign sda_w = !((!sda_oe_n && !sda_o) || tsda || mpull);

  two_wire_serial_bus u_dut (
    .clk, .nrst, .scl_i(scl_w), .sda_i(sda_w), .scl_o, .scl_oe_n, .sda_o,
    .sda_oe_n, .en, .own_addr, .gc_en, .m_go, .m_addr, .m_rw, .m_stop,
    .tx_byte, .rx_byte, .rx_valid, .tx_taken, .slv_sel, .busy,
    .is_master, .arb_lost, .nack_seen
  );

  bus_slave_model #(.ADDR(7'h50)) u_slave (
    .scl(scl_w), .sda(sda_w), .rd_byte, .pull(mpull), .addr_byte,
    .data_byte
  );

  // Pulse tallies and shortest clock period while the block is master
  always @(posedge clk) begin
    scl_q  <= scl_w;
    per    <= (scl_w && !scl_q) ? 0 : per + 1;
    if (scl_w && !scl_q && is_master && per < min_per) min_per <= per;
    n_fall <= n_fall + int'(scl_q && !scl_w);
    n_rxv  <= n_rxv + int'(rx_valid);
    n_tx   <= n_tx + int'(tx_taken);
    n_sel  <= n_sel + int'(slv_sel);
    n_arb  <= n_arb + int'(arb_lost);
    n_nack <= n_nack + int'(nack_seen);
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Cleared off the sampling edge so the tally process never races it
  task clr();
    @(negedge clk);
    {n_rxv, n_tx, n_sel, n_arb, n_nack, n_fall} = '0;
    min_per = 100000;
  endtask : clr

  task wait_busy(input logic lv);
    for (k = 0; k < 20000 && busy !== lv; k++) @(posedge clk);
    chk(busy, lv);
  endtask : wait_busy

  // Our own master on the wire, 80 ns link clock
  task tb_start();
    cyc(5);
    tsda <= 1'h1;
    cyc(5);
    tscl <= 1'h1;
  endtask : tb_start

  task tb_stop();
    cyc(2);
    tsda <= 1'h1;
    cyc(3);
    tscl <= 1'h0;
    cyc(5);
    tsda <= 1'h0;
    wait_busy(1'h0);
  endtask : tb_stop

  // Nine clocks; a 1 releases the line, the level is read late in high
  task bits9(input logic [8:0] v, output logic [8:0] rv);
    for (int i = 8; i >= 0; i--) begin
      cyc(2);
      tsda <= !v[i];
      cyc(3);
      tscl <= 1'h0;
      cyc(5);
      rv[i] = sda_w;
      tscl <= 1'h1;
    end
  endtask : bits9

  // Raises a stop request once the first byte boundary is passed
  task master(input logic [6:0] a, input logic rw, input logic [7:0] b);
    clr();
    @(posedge clk);
    m_addr  <= a;
    m_rw    <= rw;
    tx_byte <= b;
    m_stop  <= 1'h0;
    m_go    <= 1'h1;
    @(posedge clk);
    m_go <= 1'h0;
    for (k = 0; k < 9000 && n_tx == 0 && n_nack == 0
         && !(rw && n_fall >= 9); k++) @(posedge clk);
    m_stop <= 1'h1;
    wait_busy(1'h0);
    cyc(200);
  endtask : master

  task t_mwrite();
    master(7'h50, 1'h0, 8'ha5);
    chk(addr_byte, 8'ha0);
    chk(data_byte, 8'ha5);
    chk(16'(n_tx), 16'h1);
    chk(16'(n_nack), 16'h0);
    chk(min_per >= 312, 1'h1);
    $display("test master write done");
  endtask : t_mwrite

  task t_mnack();
    master(7'h51, 1'h0, 8'h33);
    chk(16'(n_nack), 16'h1);
    chk(16'(n_tx), 16'h0);
    chk(is_master, 1'h0);
    $display("test master refused done");
  endtask : t_mnack

  task t_mread();
    rd_byte <= 8'h3c;
    master(7'h50, 1'h1, 8'h00);
    chk(addr_byte, 8'ha1);
    chk(rx_byte, 8'h3c);
    chk(16'(n_rxv), 16'h1);
    $display("test master read done");
  endtask : t_mread

  task t_srx(input logic [6:0] a, input logic rw, input logic g,
             input logic ack, input logic [7:0] b);
    clr();
    @(posedge clk);
    gc_en <= g;
    tb_start();
    bits9({a, rw, 1'h1}, r);
    chk(r[0], !ack);
    if (ack) begin
      bits9({b, 1'h1}, r);
      chk(r[0], 1'h0);
      chk(rx_byte, b);
    end
    chk(16'(n_sel), 16'(ack));
    tb_stop();
    $display("test slave receive %h done", a);
  endtask : t_srx

  task t_stx();
    clr();
    @(posedge clk);
    tx_byte <= 8'hc6;
    tb_start();
    bits9({own_addr, 1'h1, 1'h1}, r);
    chk(r[0], 1'h0);
    bits9(9'h1ff, r);
    chk(r[8:1], 8'hc6);
    chk(16'(n_tx), 16'h1);
    tb_stop();
    $display("test slave transmit done");
  endtask : t_stx

  // We hold data low while the block sends a one
  task t_arb();
    clr();
    @(posedge clk);
    m_addr <= 7'h50;
    m_stop <= 1'h0;
    m_go   <= 1'h1;
    @(posedge clk);
    m_go <= 1'h0;
    for (k = 0; k < 2000 && n_fall == 0; k++) @(posedge clk);
    tsda <= 1'h1;
    for (k = 0; k < 2000 && n_arb == 0; k++) @(posedge clk);
    cyc(8);
    chk(16'(n_arb), 16'h1);
    chk({is_master, scl_oe_n, sda_oe_n}, 3'h3);
    tsda <= 1'h0;
    wait_busy(1'h0);
    cyc(200);
    $display("test arbitration done");
  endtask : t_arb

  // Enable dropped mid-address: both lines must be let go at once
  task t_dis();
    clr();
    @(posedge clk);
    m_addr <= 7'h50;
    m_rw   <= 1'h0;
    m_stop <= 1'h0;
    m_go   <= 1'h1;
    @(posedge clk);
    m_go <= 1'h0;
    for (k = 0; k < 2000 && n_fall < 3; k++) @(posedge clk);
    chk(16'(n_fall), 16'h3);
    en <= 1'h0;
    cyc(4);
    chk({scl_oe_n, sda_oe_n, busy, is_master}, 4'hc);
    en <= 1'h1;
    cyc(400);
    $display("test disable done");
  endtask : t_dis

  initial begin
    clr();
    cyc(4);
    chk({scl_oe_n, sda_oe_n, busy, is_master}, 4'hc);
    chk({scl_o, sda_o}, 2'h0);
    nrst <= 1'h1;
    en   <= 1'h1;
    cyc(4);
    chk({scl_oe_n, sda_oe_n, busy}, 3'h6);
    $display("test reset done");
    t_mwrite();
    t_dis();
    t_mnack();
    t_mread();
    t_srx(7'h2b, 1'h0, 1'h0, 1'h1, 8'h5a);
    t_srx(7'h00, 1'h0, 1'h1, 1'h1, 8'h81);
    t_srx(7'h00, 1'h0, 1'h0, 1'h0, 8'h00);
    t_srx(7'h2c, 1'h0, 1'h1, 1'h0, 8'h00);
    t_srx(7'h00, 1'h1, 1'h1, 1'h0, 8'h00);
    t_stx();
    t_arb();
    end_sim();
  end

  // Cut a hang short; a clean run needs about a quarter of this
  initial begin
    #600000;
    err_total++;
    end_sim();
  end
endmodule : test_two_wire_serial_bus
`default_nettype wire
